/* File: stxdi_serial_tx.sv */
// Purpose: serial transmit data input path, asynchronous and synchronous modes
// Assumes: link_clk runs at eight times the programmed data rate
// Notes: run settings are captured at tx start and held while transmitting
`timescale 1ns/10ps
module stxdi_serial_tx
	import stxdi_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic cmd_valid,
	input wire logic [5:0] cmd_addr,
	input wire stxdi_cfg_t cfg,
	input wire logic [15:0] sync_word,
	output stxdi_feat_t feat,
	output logic tx_active,
	output logic synth_on,
	output logic pin_input_select_n,
	output logic config_conflict,
	output logic header_busy,
	input wire logic link_clk,
	input wire logic pin_zero_in,
	output logic pin_zero_out,
	output logic pin_zero_oe,
	output logic bit_clk_out,
	output logic mod_data,
	output logic mod_data_valid
);

`include "stxdi_defines.svh"

	// ==========================================================
	// control domain declarations
	logic transmit_start_strobe;
	logic exit_to_idle_strobe;
	logic is_async_cfg;
	logic is_sync_cfg;
	logic is_serial_cfg;
	logic tx_active_ff;
	logic synth_on_ff;
	logic pin_input_select_n_ff;
	logic config_conflict_ff;
	logic header_busy_c;
	stxdi_feat_t feat_ff;
	stxdi_feat_t nxt_feat;
	logic [1:0] run_fmt_ff;
	logic run_insert_ff;
	logic run_double_ff;
	logic [15:0] run_sync_ff;

	// ==========================================================
	// link domain declarations
	logic ce_l;
	logic active_l;
	logic pin_s;
	stxdi_lstate_t lstate_ff;
	logic [2:0] phase_ff;
	logic [2:0] nxt_phase;
	logic [6:0] hdr_cnt_ff;
	logic [6:0] hdr_len;
	logic [6:0] sync_pos;
	logic hdr_bit;
	logic [7:0] dly_ff;
	logic mod_data_ff;
	logic mod_valid_ff;
	logic bclk_ff;
	logic run_is_sync;
	logic run_is_async;

	// ==========================================================
	// command decode
	assign transmit_start_strobe = cmd_valid && (cmd_addr == `STXDI_CMD_TX_START);
	assign exit_to_idle_strobe = cmd_valid && (cmd_addr == `STXDI_CMD_IDLE);

	assign is_async_cfg = (cfg.packet_format_select == `STXDI_FMT_ASYNC);
	assign is_sync_cfg = (cfg.packet_format_select == `STXDI_FMT_SYNC);
	assign is_serial_cfg = is_async_cfg || is_sync_cfg;

	// ==========================================================
	// transmit state, idle strobe wins over a simultaneous start
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_active_ff <= 1'b0;
		end else if (ce) begin
			if (exit_to_idle_strobe) begin
				tx_active_ff <= 1'b0;
			end else if (transmit_start_strobe) begin
				tx_active_ff <= 1'b1;
			end
		end
	end

	// ==========================================================
	// synthesizer power follows transmit start and idle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			synth_on_ff <= 1'b0;
		end else if (ce) begin
			if (exit_to_idle_strobe) begin
				synth_on_ff <= 1'b0;
			end else if (transmit_start_strobe) begin
				synth_on_ff <= 1'b1;
			end
		end
	end

	// ==========================================================
	// run settings captured at start, stable while the link reads them
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run_fmt_ff <= `STXDI_FMT_FIFO;
			run_insert_ff <= 1'b0;
			run_double_ff <= 1'b0;
			run_sync_ff <= 16'h0000;
		end else if (ce && transmit_start_strobe && !tx_active_ff && !header_busy_c) begin
			run_fmt_ff <= cfg.packet_format_select;
			run_insert_ff <= (cfg.sync_mode != `STXDI_SYNC_NONE);
			run_double_ff <= (cfg.sync_mode == `STXDI_SYNC_DOUBLE_A) ||
				(cfg.sync_mode == `STXDI_SYNC_DOUBLE_B);
			run_sync_ff <= sync_word;
		end
	end

	// ==========================================================
	// pin direction: low select means pin zero is an input
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_input_select_n_ff <= 1'b1;
		end else if (ce) begin
			pin_input_select_n_ff <= !(is_serial_cfg && tx_active_ff);
		end
	end

	// ==========================================================
	// effective features
	always_comb begin
		nxt_feat = '0;
		nxt_feat.fifo_bypass = is_serial_cfg;
		nxt_feat.mod_format = cfg.mod_format;
		if (is_async_cfg) begin
			nxt_feat.pkt_handler_en = 1'b0;
			nxt_feat.whitening_en = 1'b0;
			nxt_feat.interleave_en = 1'b0;
			nxt_feat.fec_en = 1'b0;
			nxt_feat.manchester_en = 1'b0;
			if (cfg.mod_format == `STXDI_MOD_MSK) begin
				nxt_feat.mod_format = `STXDI_MOD_2FSK;
			end
		end else if (is_sync_cfg && (cfg.sync_mode == `STXDI_SYNC_NONE)) begin
			nxt_feat.pkt_handler_en = 1'b0;
			nxt_feat.whitening_en = cfg.whitening_en;
			nxt_feat.interleave_en = cfg.interleave_en;
			nxt_feat.fec_en = cfg.fec_en;
			nxt_feat.manchester_en = 1'b0;
		end else if (is_sync_cfg) begin
			nxt_feat.pkt_handler_en = 1'b1;
			nxt_feat.whitening_en = cfg.whitening_en;
			nxt_feat.interleave_en = cfg.interleave_en;
			nxt_feat.fec_en = cfg.fec_en;
			nxt_feat.manchester_en = 1'b0;
		end else begin
			nxt_feat.pkt_handler_en = 1'b1;
			nxt_feat.whitening_en = cfg.whitening_en;
			nxt_feat.interleave_en = cfg.interleave_en;
			nxt_feat.fec_en = cfg.fec_en;
			nxt_feat.manchester_en = cfg.manchester_en;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			feat_ff <= '0;
		end else if (ce) begin
			feat_ff <= nxt_feat;
		end
	end

	// ==========================================================
	// settings that the serial modes cannot honour
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			config_conflict_ff <= 1'b0;
		end else if (ce) begin
			config_conflict_ff <= (is_async_cfg && (cfg.manchester_en || cfg.whitening_en ||
				cfg.interleave_en || cfg.fec_en || (cfg.mod_format == `STXDI_MOD_MSK))) ||
				(is_sync_cfg && cfg.manchester_en) ||
				(is_sync_cfg && (cfg.sync_mode == `STXDI_SYNC_NONE) &&
				(cfg.whitening_en || cfg.interleave_en || cfg.fec_en));
		end
	end

	// ==========================================================
	// crossings
	// link starts only once pin zero has turned to input
	stxdi_sync2 #(.W(2)) u_to_link (
		.clk(link_clk),
		.rst(rst),
		.d({ce, tx_active_ff && !pin_input_select_n_ff}),
		.q({ce_l, active_l})
	);

	stxdi_sync2 #(.W(1)) u_pin (
		.clk(link_clk),
		.rst(rst),
		.d(pin_zero_in),
		.q(pin_s)
	);

	stxdi_sync2 #(.W(1)) u_to_ctrl (
		.clk(clk),
		.rst(rst),
		.d(lstate_ff != STXDI_L_IDLE),
		.q(header_busy_c)
	);

	// ==========================================================
	// link domain helpers
	assign run_is_sync = (run_fmt_ff == `STXDI_FMT_SYNC);
	assign run_is_async = (run_fmt_ff == `STXDI_FMT_ASYNC);
	assign hdr_len = run_double_ff ? `STXDI_HDR_DOUBLE : `STXDI_HDR_SINGLE;
	assign sync_pos = hdr_cnt_ff - `STXDI_PREAMBLE_BITS;
	assign nxt_phase = phase_ff + 3'h1;

	// preamble alternates starting with one, then sync word msb first
	always_comb begin
		if (hdr_cnt_ff < `STXDI_PREAMBLE_BITS) begin
			hdr_bit = ~hdr_cnt_ff[0];
		end else begin
			hdr_bit = run_sync_ff[4'hf - sync_pos[3:0]];
		end
	end

	// ==========================================================
	// link state machine and bit phase
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			lstate_ff <= STXDI_L_IDLE;
			phase_ff <= `STXDI_PHASE_FIRST;
			hdr_cnt_ff <= 7'h00;
		end else if (ce_l) begin
			case (lstate_ff)
				STXDI_L_IDLE: begin
					phase_ff <= `STXDI_PHASE_FIRST;
					hdr_cnt_ff <= 7'h00;
					if (active_l && run_is_sync) begin
						lstate_ff <= run_insert_ff ? STXDI_L_HEAD : STXDI_L_PAY;
					end
				end
				STXDI_L_HEAD: begin
					phase_ff <= nxt_phase;
					if (!active_l) begin
						lstate_ff <= STXDI_L_IDLE;
					end else if (phase_ff == `STXDI_PHASE_SAMPLE) begin
						hdr_cnt_ff <= hdr_cnt_ff + 7'h01;
						if (hdr_cnt_ff == hdr_len - 7'h01) begin
							lstate_ff <= STXDI_L_PAY;
						end
					end
				end
				STXDI_L_PAY: begin
					phase_ff <= nxt_phase;
					if (!active_l) begin
						lstate_ff <= STXDI_L_IDLE;
					end
				end
				default: begin
					lstate_ff <= STXDI_L_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// bit clock to the host, running only during payload
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			bclk_ff <= 1'b0;
		end else if (ce_l) begin
			bclk_ff <= (lstate_ff == STXDI_L_PAY) && active_l && !nxt_phase[2];
		end
	end

	// ==========================================================
	// eight bit delay line fed three link clocks after the falling bit clock edge
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			dly_ff <= 8'h00;
		end else if (ce_l) begin
			if (lstate_ff == STXDI_L_IDLE) begin
				dly_ff <= 8'h00;
			end else if ((lstate_ff == STXDI_L_PAY) && (phase_ff == `STXDI_PHASE_SAMPLE)) begin
				dly_ff <= {dly_ff[6:0], pin_s};
			end
		end
	end

	// ==========================================================
	// data to the modulator
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			mod_data_ff <= 1'b0;
			mod_valid_ff <= 1'b0;
		end else if (ce_l) begin
			mod_valid_ff <= 1'b0;
			if (active_l && run_is_async) begin
				mod_data_ff <= pin_s;
				mod_valid_ff <= 1'b1;
			end else if ((lstate_ff == STXDI_L_HEAD) && active_l &&
				(phase_ff == `STXDI_PHASE_SAMPLE)) begin
				mod_data_ff <= hdr_bit;
				mod_valid_ff <= 1'b1;
			end else if ((lstate_ff == STXDI_L_PAY) && active_l &&
				(phase_ff == `STXDI_PHASE_SAMPLE)) begin
				mod_data_ff <= dly_ff[7];
				mod_valid_ff <= 1'b1;
			end
		end
	end

	// ==========================================================
	// outputs
	assign feat = feat_ff;
	assign tx_active = tx_active_ff;
	assign synth_on = synth_on_ff;
	assign pin_input_select_n = pin_input_select_n_ff;
	assign config_conflict = config_conflict_ff;
	assign header_busy = header_busy_c;
	assign pin_zero_out = 1'b0;
	assign pin_zero_oe = pin_input_select_n_ff;
	assign bit_clk_out = bclk_ff;
	assign mod_data = mod_data_ff;
	assign mod_data_valid = mod_valid_ff;

endmodule

/* File: stxdi_defines.svh */
// Purpose: constants for the serial transmit data input path
// Assumes: included by bare name after the package
// Notes: values are hexadecimal and sized to the signal they meet
`ifndef STXDI_DEFINES_SVH
`define STXDI_DEFINES_SVH

// ==========================================================
// packet format select codes
`define STXDI_FMT_FIFO 2'h0
`define STXDI_FMT_SYNC 2'h1
`define STXDI_FMT_ASYNC 2'h3

// ==========================================================
// command strobe addresses
`define STXDI_CMD_TX_START 6'h35
`define STXDI_CMD_IDLE 6'h36

// ==========================================================
// modulation format codes
`define STXDI_MOD_2FSK 3'h0
`define STXDI_MOD_MSK 3'h7

// ==========================================================
// sync mode codes
`define STXDI_SYNC_NONE 3'h0
`define STXDI_SYNC_DOUBLE_A 3'h3
`define STXDI_SYNC_DOUBLE_B 3'h7

// ==========================================================
// link timing: link clock runs at eight times the data rate
`define STXDI_PHASE_FIRST 3'h0
`define STXDI_PHASE_SAMPLE 3'h6
`define STXDI_LATENCY_BITS 4'h8

// ==========================================================
// header lengths in bits
`define STXDI_PREAMBLE_BITS 7'h20
`define STXDI_HDR_SINGLE 7'h30
`define STXDI_HDR_DOUBLE 7'h40

`endif

/* File: stxdi_pkg.sv */
// Purpose: types shared by the serial transmit data input path
// Assumes: nothing
// Notes: constants live in stxdi_defines.svh
package stxdi_pkg;

	// ==========================================================
	// link state, gray coded along idle -> header -> payload
	typedef enum logic [1:0] {
		STXDI_L_IDLE = 2'h0,
		STXDI_L_HEAD = 2'h1,
		STXDI_L_PAY = 2'h3
	} stxdi_lstate_t;

	// ==========================================================
	// configuration requested by software
	typedef struct packed {
		logic [1:0] packet_format_select;
		logic [2:0] sync_mode;
		logic [2:0] mod_format;
		logic manchester_en;
		logic whitening_en;
		logic interleave_en;
		logic fec_en;
	} stxdi_cfg_t;

	// ==========================================================
	// effective features seen by the rest of the modulator
	typedef struct packed {
		logic fifo_bypass;
		logic pkt_handler_en;
		logic whitening_en;
		logic interleave_en;
		logic fec_en;
		logic manchester_en;
		logic [2:0] mod_format;
	} stxdi_feat_t;

endpackage

/* File: stxdi_sync2.sv */
// Purpose: two flip-flop level synchroniser
// Assumes: input is a level that is stable for several destination clocks
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module stxdi_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_ff;

	// ==========================================================
	// two stages
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_ff <= '0;
			q <= '0;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end

endmodule

/* File: stxdi_serial_tx_asserts.sv */
// Purpose: concurrent checks on the serial transmit data input path
// Assumes: cfg held steady while transmitting
// Notes: bound to every stxdi_serial_tx
`timescale 1ns/10ps
`include "stxdi_defines.svh"
module stxdi_serial_tx_asserts
	import stxdi_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic cmd_valid,
	input wire logic [5:0] cmd_addr,
	input wire stxdi_cfg_t cfg,
	input wire stxdi_feat_t feat,
	input wire logic tx_active,
	input wire logic synth_on,
	input wire logic pin_input_select_n,
	input wire logic config_conflict,
	input wire logic link_clk,
	input wire logic pin_zero_oe,
	input wire logic bit_clk_out
);
	// ==========================================================
	// sequences
	sequence s_cmd(logic [5:0] a);
		ce && cmd_valid && cmd_addr == a;
	endsequence
	sequence s_serial;
		tx_active && ce && cfg.packet_format_select[0];
	endsequence
	sequence s_async;
		ce && cfg.packet_format_select == `STXDI_FMT_ASYNC;
	endsequence
	// ==========================================================
	// control domain
	chk_start_sets_active: assert property (@(posedge clk) disable iff (rst)
		s_cmd(`STXDI_CMD_TX_START) |=> tx_active && synth_on) else $error("start missed");
	chk_idle_stops_tx: assert property (@(posedge clk) disable iff (rst)
		s_cmd(`STXDI_CMD_IDLE) |=> !tx_active && !synth_on) else $error("idle missed");
	chk_async_bypass_fifo: assert property (@(posedge clk) disable iff (rst)
		s_async |=> feat.fifo_bypass && !feat.pkt_handler_en) else $error("no bypass");
	chk_async_features_off: assert property (@(posedge clk) disable iff (rst)
		s_async |=> !(feat.whitening_en | feat.interleave_en | feat.fec_en | feat.manchester_en))
		else $error("feature on");
	chk_async_no_msk: assert property (@(posedge clk) disable iff (rst)
		s_async |=> feat.mod_format != `STXDI_MOD_MSK) else $error("msk in async");
	chk_msk_conflict_flag: assert property (@(posedge clk) disable iff (rst)
		s_async ##0 cfg.mod_format == `STXDI_MOD_MSK |=> config_conflict)
		else $error("msk not flagged");
	chk_sync_nrz_flag: assert property (@(posedge clk) disable iff (rst)
		ce && cfg.packet_format_select == `STXDI_FMT_SYNC && cfg.manchester_en |=> config_conflict)
		else $error("manchester not flagged");
	chk_pin_input_run: assert property (@(posedge clk) disable iff (rst)
		s_serial ##1 s_serial |-> !pin_input_select_n) else $error("pin not input");
	chk_pin_oe_select: assert property (@(posedge clk) disable iff (rst)
		pin_zero_oe == pin_input_select_n) else $error("oe mismatch");
	// ==========================================================
	// link domain
	chk_bitclk_low_half: assert property (@(posedge link_clk) disable iff (rst)
		$fell(bit_clk_out) |-> !bit_clk_out[*3]) else $error("bit clock low short");
endmodule
bind stxdi_serial_tx stxdi_serial_tx_asserts u_stxdi_serial_tx_asserts (.clk, .rst, .ce,
	.cmd_valid, .cmd_addr, .cfg, .feat, .tx_active, .synth_on, .pin_input_select_n,
	.config_conflict, .link_clk, .pin_zero_oe, .bit_clk_out);

/* File: stxdi_host_model.sv */
// Purpose: host model driving serial transmit data on pin zero
// Assumes: link_clk is the device link clock
// Notes: async bits last eight link clocks, sync bits follow bit clock rises
`timescale 1ns/10ps
module stxdi_host_model (
	input wire logic link_clk,
	input wire logic load,
	input wire logic async_mode,
	input wire logic bit_clk,
	input wire logic [15:0] pattern,
	output logic host_data
);
	logic [15:0] pat_ff;
	logic [2:0] cnt_ff;
	logic clk_q_ff;
	initial host_data = 1'b0;
	// ==========================================================
	// bit source, payload only in sync mode
	always @(posedge link_clk) begin
		clk_q_ff <= bit_clk;
		cnt_ff <= load ? 3'h0 : cnt_ff + 3'h1;
		if (load) begin
			pat_ff <= pattern;
		end else if (async_mode ? cnt_ff == 3'h7 : bit_clk && !clk_q_ff) begin
			host_data <= pat_ff[15];
			pat_ff <= {pat_ff[14:0], pat_ff[15]};
		end
	end
endmodule

/* File: stxdi_serial_tx_test.sv */
// Purpose: self-checking bench for stxdi_serial_tx
// Assumes: host model on pin zero
// Notes: inputs change at falling clk edge
`timescale 1ns/10ps
`include "stxdi_defines.svh"
module stxdi_serial_tx_test import stxdi_pkg::*; ;
	logic clk = 0, rst = 1, ce = 1, cmd_valid = 0, link_clk = 0;
	logic [5:0] cmd_addr = 6'h00;
	stxdi_cfg_t cfg = '0;
	logic [15:0] sync_word = 16'h9a3c;
	stxdi_feat_t feat;
	logic tx_active, synth_on, pin_input_select_n, config_conflict, header_busy;
	logic pin_zero_out, pin_zero_oe, bit_clk_out, mod_data, mod_data_valid, host_data;
	logic load = 1, async_mode = 0, pq, dq;
	logic [63:0] col = '0;
	int col_n = 0, col_lim = 0, pin_tg = 0, dat_tg = 0, val_n = 0, errors = 0;
	int num_checks = 0, cycles = 0;
	wire pin_wire = pin_zero_oe ? pin_zero_out : host_data;
	always #50 clk = ~clk;
	initial #1.7 forever #3 link_clk = ~link_clk;
	stxdi_serial_tx u_stxdi_serial_tx (.clk, .rst, .ce, .cmd_valid, .cmd_addr, .cfg,
		.sync_word, .feat, .tx_active, .synth_on, .pin_input_select_n, .config_conflict,
		.header_busy, .link_clk, .pin_zero_in(pin_wire), .pin_zero_out, .pin_zero_oe,
		.bit_clk_out, .mod_data, .mod_data_valid);
	stxdi_host_model u_stxdi_host_model (.link_clk, .load, .async_mode,
		.bit_clk(bit_clk_out), .pattern(16'hb4c3), .host_data);
	// ==========================================================
	// link monitor
	always @(posedge link_clk) begin
		pq <= pin_wire;
		dq <= mod_data;
		pin_tg <= pin_tg + (pin_wire !== pq);
		dat_tg <= dat_tg + (mod_data !== dq);
		val_n <= val_n + mod_data_valid;
		if (mod_data_valid && col_n < col_lim) begin
			col <= {col[62:0], mod_data};
			col_n <= col_n + 1;
		end
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			errors++;
			finish_test();
		end
	end
	// ==========================================================
	// helpers
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic strobe(input logic [5:0] a);
		@(negedge clk);
		cmd_valid = 1;
		cmd_addr = a;
		@(negedge clk);
		cmd_valid = 0;
		repeat (2) @(negedge clk);
	endtask
	task automatic set_cfg(input stxdi_cfg_t c);
		cfg = c;
		repeat (2) @(negedge clk);
	endtask
	task automatic stop_tx();
		strobe(`STXDI_CMD_IDLE);
		check("tx_active", tx_active, 0);
		check("synth_on", synth_on, 0);
		check("pin_sel_n", pin_input_select_n, 1);
		repeat (40) @(negedge clk);
		check("hdr_idle", header_busy, 0);
	endtask
	task automatic finish_test();
		if (errors == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	task automatic test_async();
		async_mode = 1;
		set_cfg('{2'h3, 3'h0, `STXDI_MOD_MSK, 1'b1, 1'b1, 1'b1, 1'b1});
		check("bypass", {feat.fifo_bypass, feat.pkt_handler_en}, 2'b10);
		check("features", {feat.whitening_en, feat.interleave_en, feat.fec_en,
			feat.manchester_en}, 0);
		check("mod_format", feat.mod_format, `STXDI_MOD_2FSK);
		check("conflict", config_conflict, 1);
		strobe(`STXDI_CMD_TX_START);
		check("active", {tx_active, synth_on}, 2'b11);
		check("pin_in", {pin_input_select_n, pin_zero_oe}, 2'b00);
		val_n = 0;
		pin_tg = 0;
		dat_tg = 0;
		repeat (40) @(negedge clk);
		check("oversample", val_n >= 300, 1);
		check("pin_follow", pin_tg > 20 && dat_tg <= pin_tg + 2 && dat_tg + 2 >= pin_tg, 1);
		stop_tx();
		async_mode = 0;
	endtask
	task automatic test_refused();
		strobe(6'h3d);
		check("bad_addr", tx_active, 0);
		ce = 0;
		strobe(`STXDI_CMD_TX_START);
		ce = 1;
		check("ce_low", tx_active, 0);
		set_cfg('{2'h1, 3'h1, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0});
		check("nrz", config_conflict, 1);
		set_cfg('{2'h1, 3'h0, 3'h0, 1'b0, 1'b1, 1'b0, 1'b0});
		check("no_insert", config_conflict, 1);
	endtask
	task automatic run_sync(input logic [2:0] sm, input int n, input logic [63:0] exp);
		load = 1;
		set_cfg('{2'h1, sm, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0});
		load = 0;
		col = '0;
		col_n = 0;
		col_lim = n;
		strobe(`STXDI_CMD_TX_START);
		@(negedge clk);
		check("hdr_busy", header_busy, 1);
		check("sync_pin_in", pin_input_select_n, 0);
		for (int i = 0; i < 200 && col_n < n; i++) @(negedge clk);
		check("bits", col, exp);
		stop_tx();
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		@(negedge clk);
		check("reset", {tx_active, synth_on, pin_input_select_n, pin_zero_oe, mod_data_valid,
			bit_clk_out}, 6'b001100);
		rst = 0;
		load = 0;
		test_refused();
		test_async();
		run_sync(`STXDI_SYNC_NONE, 16, 64'h00b4);
		run_sync(3'h1, 48, {16'h0, 32'haaaaaaaa, 16'h9a3c});
		run_sync(`STXDI_SYNC_DOUBLE_A, 64, {32'haaaaaaaa, 16'h9a3c, 16'h9a3c});
		run_sync(`STXDI_SYNC_DOUBLE_B, 64, {32'haaaaaaaa, 16'h9a3c, 16'h9a3c});
		finish_test();
	end
endmodule
